// [hdl/dsg_pkg.sv]
package dsg_pkg;
    // ==================================================================
    // Register map (byte addresses, low 12 bits)
    localparam logic [11:0] ADDR_RUN_GATE = 12'h104;
    localparam logic [11:0] ADDR_SLEEP_GATE = 12'h114;
    localparam logic [11:0] ADDR_DEEP_GATE = 12'h124;
    localparam logic [11:0] ADDR_RUN_CONFIG = 12'h060;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h200;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h204;
    localparam logic [11:0] ADDR_GATE_STATE = 12'h208;
    // ==================================================================
    // Field layout
    localparam int NUM_PERIPH = 6;
    localparam logic [31:0] GATE_WRITABLE = 32'h0003_1013;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int AUTO_GATE_BIT = 27;
    localparam logic [31:0] CONFIG_WRITABLE = 32'h0800_0000;
    // Peripheral index to bit position: async0, async1, sync0, twowire0, gp0, gp1
    localparam int PERIPH_BIT [0:NUM_PERIPH-1] = '{0, 1, 4, 12, 16, 17};
    // ==================================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==================================================================
    // State encodings
    typedef enum logic [1:0] {
        DSG_W_IDLE = 2'h1,
        DSG_W_RESP = 2'h2
    } dsg_wr_state_t;
    typedef enum logic [1:0] {
        DSG_R_IDLE = 2'h1,
        DSG_R_RESP = 2'h2
    } dsg_rd_state_t;
    typedef enum logic [2:0] {
        DSG_MODE_RUN = 3'h1,
        DSG_MODE_SLEEP = 3'h2,
        DSG_MODE_DEEP = 3'h4
    } dsg_mode_t;
endpackage

// [hdl/dsg_gate_if.sv]
`timescale 1ns/1ns
interface dsg_gate_if;
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic auto_gate;
    logic sleep_req;
    logic deep_req;
    logic [dsg_pkg::NUM_PERIPH-1:0] access;
    logic [dsg_pkg::NUM_PERIPH-1:0] gate_en;
    logic [dsg_pkg::NUM_PERIPH-1:0] fault;
    dsg_pkg::dsg_mode_t mode;
    modport ctrl (
        output run_gate, sleep_gate, deep_gate, auto_gate, sleep_req, deep_req, access,
        input gate_en, fault, mode
    );
    modport sel (
        input run_gate, sleep_gate, deep_gate, auto_gate, sleep_req, deep_req, access,
        output gate_en, fault, mode
    );
endinterface

// [hdl/dsg_gate_sel.sv]
`timescale 1ns/1ns
module dsg_gate_sel (
    input wire logic clk,
    input wire logic rst,
    dsg_gate_if.sel g
);
    // ==================================================================
    // Power mode tracking
    dsg_pkg::dsg_mode_t mode;
    dsg_pkg::dsg_mode_t next_mode;
    logic [31:0] chosen;
    logic [dsg_pkg::NUM_PERIPH-1:0] gate_en;
    logic [dsg_pkg::NUM_PERIPH-1:0] next_gate_en;
    logic [dsg_pkg::NUM_PERIPH-1:0] fault;
    logic [dsg_pkg::NUM_PERIPH-1:0] next_fault;

    always_comb begin
        if (g.deep_req) begin
            next_mode = dsg_pkg::DSG_MODE_DEEP;
        end else if (g.sleep_req) begin
            next_mode = dsg_pkg::DSG_MODE_SLEEP;
        end else begin
            next_mode = dsg_pkg::DSG_MODE_RUN;
        end
    end

    // ==================================================================
    // Gate source selection, stored registers only read
    always_comb begin
        case (mode)
            dsg_pkg::DSG_MODE_RUN: begin
                chosen = g.run_gate;
            end
            dsg_pkg::DSG_MODE_SLEEP: begin
                chosen = g.auto_gate ? g.sleep_gate : g.run_gate;
            end
            dsg_pkg::DSG_MODE_DEEP: begin
                chosen = g.auto_gate ? g.deep_gate : g.run_gate;
            end
            default: begin
                chosen = g.run_gate;
            end
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < dsg_pkg::NUM_PERIPH; i = i + 1) begin : g_periph
            always_comb begin
                next_gate_en[i] = chosen[dsg_pkg::PERIPH_BIT[i]];
                next_fault[i] = g.access[i] & ~gate_en[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= dsg_pkg::DSG_MODE_RUN;
            gate_en <= '0;
            fault <= '0;
        end else begin
            mode <= next_mode;
            gate_en <= next_gate_en;
            fault <= next_fault;
        end
    end

    assign g.gate_en = gate_en;
    assign g.fault = fault;
    assign g.mode = mode;
endmodule

// [hdl/dsg_top.sv]
`timescale 1ns/1ns
// Behaviour
// - Each writable gate bit enables the clock of one peripheral.
// - Access to a peripheral whose clock is off raises a bus fault.
// - All gate bits reset to zero, every peripheral unclocked.
// - Deep-sleep gate register sits at 0x124 and steers Deep-Sleep clocks.
// - Sleep-mode gates apply only while the auto gating bit is set.
// - Bit 17 gates counter one, bit 16 gates counter zero.
// - Bit 12 gates two-wire serial module zero.
// - Bit 4 gates synchronous serial module zero.
// - Bit 1 gates async serial one, bit 0 async serial zero.
// - Reserved bits are read-only zero; software preserves them.
module dsg_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic [dsg_pkg::NUM_PERIPH-1:0] periph_access,
    output logic [dsg_pkg::NUM_PERIPH-1:0] periph_clk_en,
    output logic [dsg_pkg::NUM_PERIPH-1:0] periph_fault,
    output logic irq
);
    // ==================================================================
    // Registers
    logic [31:0] run_clock_gate_one;
    logic [31:0] sleep_clock_gate_one;
    logic [31:0] deep_sleep_clock_gate_one;
    logic [31:0] run_mode_clock_config;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [31:0] next_run_gate;
    logic [31:0] next_sleep_gate;
    logic [31:0] next_deep_gate;
    logic [31:0] next_config;
    logic [31:0] next_status;
    logic [31:0] next_mask;
    logic next_irq;
    logic [31:0] fault_vec;
    logic [31:0] state_vec;

    // ==================================================================
    // Write channel state
    dsg_pkg::dsg_wr_state_t wstate;
    dsg_pkg::dsg_wr_state_t next_wstate;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wr_commit;
    logic [31:0] wr_mask;
    logic wr_mapped;

    // ==================================================================
    // Read channel state
    dsg_pkg::dsg_rd_state_t rstate;
    dsg_pkg::dsg_rd_state_t next_rstate;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ==================================================================
    // Gate selector
    dsg_gate_if gif ();

    assign gif.run_gate = run_clock_gate_one;
    assign gif.sleep_gate = sleep_clock_gate_one;
    assign gif.deep_gate = deep_sleep_clock_gate_one;
    assign gif.auto_gate = run_mode_clock_config[dsg_pkg::AUTO_GATE_BIT];
    assign gif.sleep_req = sleep_req;
    assign gif.deep_req = deep_sleep_req;
    assign gif.access = periph_access;

    dsg_gate_sel u_sel (
        .clk(clk),
        .rst(rst),
        .g(gif.sel)
    );

    assign periph_clk_en = gif.gate_en;
    assign periph_fault = gif.fault;

    // ==================================================================
    // Peripheral vectors placed at their gate bit positions
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bitmap
            localparam int IDX = (i == dsg_pkg::PERIPH_BIT[0]) ? 0 :
                                 (i == dsg_pkg::PERIPH_BIT[1]) ? 1 :
                                 (i == dsg_pkg::PERIPH_BIT[2]) ? 2 :
                                 (i == dsg_pkg::PERIPH_BIT[3]) ? 3 :
                                 (i == dsg_pkg::PERIPH_BIT[4]) ? 4 :
                                 (i == dsg_pkg::PERIPH_BIT[5]) ? 5 : -1;
            if (IDX >= 0) begin : g_used
                assign fault_vec[i] = gif.fault[IDX];
                assign state_vec[i] = gif.gate_en[IDX];
            end else begin : g_rsvd
                assign fault_vec[i] = 1'b0;
                assign state_vec[i] = 1'b0;
            end
        end
    endgenerate

    // ==================================================================
    // Write channel: address and data in either order
    always_comb begin
        next_wstate = wstate;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wr_commit = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        case (wstate)
            dsg_pkg::DSG_W_IDLE: begin
                if (next_aw_held && next_w_held) begin
                    wr_commit = 1'b1;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = wr_mapped ? dsg_pkg::RESP_OKAY : dsg_pkg::RESP_SLVERR;
                    next_wstate = dsg_pkg::DSG_W_RESP;
                end
            end
            dsg_pkg::DSG_W_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_wstate = dsg_pkg::DSG_W_IDLE;
                end
            end
            default: begin
                next_wstate = dsg_pkg::DSG_W_IDLE;
                next_bvalid = 1'b0;
            end
        endcase
        next_awready = (next_wstate == dsg_pkg::DSG_W_IDLE) && !next_aw_held;
        next_wready = (next_wstate == dsg_pkg::DSG_W_IDLE) && !next_w_held;
    end

    always_comb begin
        wr_mapped = (next_aw_addr == dsg_pkg::ADDR_RUN_GATE) ||
                    (next_aw_addr == dsg_pkg::ADDR_SLEEP_GATE) ||
                    (next_aw_addr == dsg_pkg::ADDR_DEEP_GATE) ||
                    (next_aw_addr == dsg_pkg::ADDR_RUN_CONFIG) ||
                    (next_aw_addr == dsg_pkg::ADDR_IRQ_STATUS) ||
                    (next_aw_addr == dsg_pkg::ADDR_IRQ_MASK) ||
                    (next_aw_addr == dsg_pkg::ADDR_GATE_STATE);
        wr_mask = {{8{next_w_strb[3]}}, {8{next_w_strb[2]}},
                   {8{next_w_strb[1]}}, {8{next_w_strb[0]}}};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wstate <= dsg_pkg::DSG_W_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dsg_pkg::RESP_OKAY;
        end else begin
            wstate <= next_wstate;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // ==================================================================
    // Register updates
    always_comb begin
        next_run_gate = run_clock_gate_one;
        next_sleep_gate = sleep_clock_gate_one;
        next_deep_gate = deep_sleep_clock_gate_one;
        next_config = run_mode_clock_config;
        next_mask = irq_mask;
        next_status = irq_status;
        if (wr_commit) begin
            case (next_aw_addr)
                dsg_pkg::ADDR_RUN_GATE: begin
                    next_run_gate = ((run_clock_gate_one & ~wr_mask) |
                                     (next_w_data & wr_mask)) & dsg_pkg::GATE_WRITABLE;
                end
                dsg_pkg::ADDR_SLEEP_GATE: begin
                    next_sleep_gate = ((sleep_clock_gate_one & ~wr_mask) |
                                       (next_w_data & wr_mask)) & dsg_pkg::GATE_WRITABLE;
                end
                dsg_pkg::ADDR_DEEP_GATE: begin
                    next_deep_gate = ((deep_sleep_clock_gate_one & ~wr_mask) |
                                      (next_w_data & wr_mask)) & dsg_pkg::GATE_WRITABLE;
                end
                dsg_pkg::ADDR_RUN_CONFIG: begin
                    next_config = ((run_mode_clock_config & ~wr_mask) |
                                   (next_w_data & wr_mask)) & dsg_pkg::CONFIG_WRITABLE;
                end
                dsg_pkg::ADDR_IRQ_MASK: begin
                    next_mask = ((irq_mask & ~wr_mask) |
                                 (next_w_data & wr_mask)) & dsg_pkg::GATE_WRITABLE;
                end
                dsg_pkg::ADDR_IRQ_STATUS: begin
                    next_status = irq_status & ~(next_w_data & wr_mask);
                end
                default: begin
                    next_config = run_mode_clock_config;
                end
            endcase
        end
        // Fault set wins over a clear in the same cycle
        next_status = next_status | fault_vec;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_clock_gate_one <= dsg_pkg::GATE_RESET;
            sleep_clock_gate_one <= dsg_pkg::GATE_RESET;
            deep_sleep_clock_gate_one <= dsg_pkg::GATE_RESET;
            run_mode_clock_config <= dsg_pkg::CONFIG_RESET;
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            run_clock_gate_one <= next_run_gate;
            sleep_clock_gate_one <= next_sleep_gate;
            deep_sleep_clock_gate_one <= next_deep_gate;
            run_mode_clock_config <= next_config;
            irq_status <= next_status;
            irq_mask <= next_mask;
            irq <= next_irq;
        end
    end

    // ==================================================================
    // Read channel
    always_comb begin
        next_rstate = rstate;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        case (rstate)
            dsg_pkg::DSG_R_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_rvalid = 1'b1;
                    next_rresp = dsg_pkg::RESP_OKAY;
                    next_rstate = dsg_pkg::DSG_R_RESP;
                    case (s_axi_araddr)
                        dsg_pkg::ADDR_RUN_GATE: next_rdata = run_clock_gate_one;
                        dsg_pkg::ADDR_SLEEP_GATE: next_rdata = sleep_clock_gate_one;
                        dsg_pkg::ADDR_DEEP_GATE: next_rdata = deep_sleep_clock_gate_one;
                        dsg_pkg::ADDR_RUN_CONFIG: next_rdata = run_mode_clock_config;
                        dsg_pkg::ADDR_IRQ_STATUS: next_rdata = irq_status;
                        dsg_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
                        dsg_pkg::ADDR_GATE_STATE: next_rdata = state_vec;
                        default: begin
                            next_rdata = '0;
                            next_rresp = dsg_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            dsg_pkg::DSG_R_RESP: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_rstate = dsg_pkg::DSG_R_IDLE;
                end
            end
            default: begin
                next_rstate = dsg_pkg::DSG_R_IDLE;
                next_rvalid = 1'b0;
            end
        endcase
        next_arready = (next_rstate == dsg_pkg::DSG_R_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rstate <= dsg_pkg::DSG_R_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= dsg_pkg::RESP_OKAY;
        end else begin
            rstate <= next_rstate;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule

// [bench/dsg_periph_model.sv]
`timescale 1ns/1ns
// ==================================================================
// Gated peripherals: access pulses, fault capture
module dsg_periph_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] touch,
    input wire logic clear,
    input wire logic [5:0] periph_fault,
    output logic [5:0] periph_access,
    output logic [5:0] caught
);
    always_ff @(posedge clk) begin
        if (rst) begin
            periph_access <= 6'h00;
            caught <= 6'h00;
        end else begin
            periph_access <= touch;
            caught <= clear ? 6'h00 : (caught | periph_fault);
        end
    end
endmodule

// [bench/dsg_top_assertions.sv]
`timescale 1ns/1ns
// ==================================================================
// Port checks
module dsg_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] periph_access,
    input wire logic [5:0] periph_clk_en,
    input wire logic [5:0] periph_fault,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_fault_cause: assert property (1'b1 |=>
        periph_fault == $past(periph_access & ~periph_clk_en)) else $error("bad fault");
    a_reset_clear: assert property ($fell(rst) |->
        periph_clk_en == 6'h00 && !irq && !s_axi_bvalid) else $error("bad reset");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no read answer");
    a_w_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0 && !s_axi_arready) else $error("bad error read");
endmodule
bind dsg_top dsg_top_chk chk (.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .periph_access(periph_access), .periph_clk_en(periph_clk_en),
    .periph_fault(periph_fault), .irq(irq));

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic clk, rst, irq, clear, sleep_req, deep_sleep_req;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [5:0] periph_access, periph_clk_en, periph_fault, touch, caught;
    int n_mismatch, tests_run;
    int bit_pos [0:5] = '{0, 1, 4, 12, 16, 17};
    dsg_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .periph_access(periph_access),
        .periph_clk_en(periph_clk_en), .periph_fault(periph_fault), .irq(irq));
    dsg_periph_model peer (.clk(clk), .rst(rst), .touch(touch), .clear(clear),
        .periph_fault(periph_fault), .periph_access(periph_access), .caught(caught));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==================================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 40) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok) && n < 40) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        guard(n);
        n = 0;
        while (!s_axi_bvalid && n < 40) begin
            @(posedge clk);
            n++;
        end
        guard(n);
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!s_axi_bvalid && n < 40);
        guard(n);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        guard(n);
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!s_axi_rvalid && n < 40);
        guard(n);
        rd = s_axi_rdata;
        chk(s_axi_rdata, ex);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poke(input logic [5:0] v);
        touch <= v;
        @(posedge clk);
        touch <= 6'h00;
        tick(4);
    endtask
    // ==================================================================
    // Sequence
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {sleep_req, deep_sleep_req, clear} = 3'h0;
        touch = 6'h00;
        n_mismatch = 0;
        tests_run = 0;
        tick(8);
        rst <= 1'b0;
        tick(2);
        rdc(dsg_pkg::ADDR_DEEP_GATE, 32'h0, 2'h0);
        rdc(dsg_pkg::ADDR_RUN_GATE, 32'h0, 2'h0);
        chk(32'(periph_clk_en), 32'h0);
        wr(dsg_pkg::ADDR_DEEP_GATE, 32'hffff_ffff, 2'h0);
        rdc(dsg_pkg::ADDR_DEEP_GATE, 32'h0003_1013, 2'h0);
        wr(dsg_pkg::ADDR_DEEP_GATE, rd & ~32'h1, 2'h0);
        rdc(dsg_pkg::ADDR_DEEP_GATE, 32'h0003_1012, 2'h0);
        wr(12'h300, 32'h1, 2'h2);
        rdc(12'h300, 32'h0, 2'h2);
        for (int i = 0; i < 6; i++) begin
            wr(dsg_pkg::ADDR_RUN_GATE, 32'h1 << bit_pos[i], 2'h0);
            tick(2);
            chk(32'(periph_clk_en), 32'h1 << i);
        end
        wr(dsg_pkg::ADDR_RUN_GATE, 32'h0, 2'h0);
        tick(2);
        poke(6'h3f);
        chk(32'(caught), 32'h3f);
        rdc(dsg_pkg::ADDR_IRQ_STATUS, 32'h0003_1013, 2'h0);
        chk(32'(irq), 32'h0);
        wr(dsg_pkg::ADDR_IRQ_MASK, 32'h10, 2'h0);
        tick(2);
        chk(32'(irq), 32'h1);
        wr(dsg_pkg::ADDR_IRQ_STATUS, 32'h0003_1013, 2'h0);
        tick(2);
        chk(32'(irq), 32'h0);
        clear <= 1'b1;
        tick(1);
        clear <= 1'b0;
        wr(dsg_pkg::ADDR_RUN_GATE, 32'h0003_1013, 2'h0);
        tick(2);
        poke(6'h3f);
        chk(32'(caught), 32'h0);
        wr(dsg_pkg::ADDR_DEEP_GATE, 32'h0000_0011, 2'h0);
        wr(dsg_pkg::ADDR_SLEEP_GATE, 32'h0000_1000, 2'h0);
        deep_sleep_req <= 1'b1;
        tick(3);
        chk(32'(periph_clk_en), 32'h3f);
        wr(dsg_pkg::ADDR_RUN_CONFIG, 32'h0800_0000, 2'h0);
        tick(2);
        chk(32'(periph_clk_en), 32'h05);
        poke(6'h02);
        chk(32'(caught), 32'h02);
        rdc(dsg_pkg::ADDR_IRQ_STATUS, 32'h0000_0002, 2'h0);
        deep_sleep_req <= 1'b0;
        sleep_req <= 1'b1;
        tick(3);
        chk(32'(periph_clk_en), 32'h08);
        rdc(dsg_pkg::ADDR_GATE_STATE, 32'h0000_1000, 2'h0);
        rdc(dsg_pkg::ADDR_SLEEP_GATE, 32'h0000_1000, 2'h0);
        sleep_req <= 1'b0;
        tick(3);
        chk(32'(periph_clk_en), 32'h3f);
        rdc(dsg_pkg::ADDR_DEEP_GATE, 32'h0000_0011, 2'h0);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        rdc(dsg_pkg::ADDR_DEEP_GATE, 32'h0, 2'h0);
        chk(32'(periph_clk_en), 32'h0);
        wrap_up();
    end
endmodule
